// File: core/dioci_evcnt.sv
`timescale 1ns/1ps
module dioci_evcnt (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic evt,
	input wire logic clr,
	output logic [dioci_pkg::DIOCI_EVT_W-1:0] count
);
	import dioci_pkg::*;

	logic [DIOCI_EVT_W-1:0] count_ff;
	logic [DIOCI_EVT_W-1:0] nxt_count;

	// An event in the clearing cycle is kept, so a fetch-and-clear never drops a count.
	assign nxt_count = clr ? {{(DIOCI_EVT_W-1){1'b0}}, evt} :
		(evt && count_ff != DIOCI_EVT_MAX) ? count_ff + 1'b1 : count_ff;

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			count_ff <= '0;
		end else begin
			count_ff <= nxt_count;
		end
	end

	assign count = count_ff;

endmodule : dioci_evcnt

// File: core/dioci_linesel.sv
`timescale 1ns/1ps
module dioci_linesel (
	input wire logic [7:0] char_hi,
	input wire logic [7:0] char_lo,
	input wire logic dec_form,
	input wire logic [6:0] nlines,
	output logic [5:0] idx,
	output logic ok
);
	import dioci_pkg::*;

	logic [4:0] nib_hi;
	logic [4:0] nib_lo;
	logic [7:0] val;
	logic digits_ok;

	assign nib_hi = dioci_char_nibble(char_hi);
	assign nib_lo = dioci_char_nibble(char_lo);
	// Hex bit form and decimal position form land on the same line index.
	assign val = dec_form ? 8'(nib_hi[3:0] * 4'ha + nib_lo[3:0]) : {nib_hi[3:0], nib_lo[3:0]};
	assign digits_ok = dec_form ? (nib_hi < 5'h0a && nib_lo < 5'h0a) : (!nib_hi[4] && !nib_lo[4]);
	assign ok = digits_ok && (val < {1'b0, nlines});
	assign idx = val[5:0];

endmodule : dioci_linesel

// File: core/dioci_top.sv
`timescale 1ns/1ps
// Functional notes
// - Stored stream mode applies at every power-up.
// - Stream modes need unlock, except stream off.
// - Parallel read returns the lines within the word length, word-length digits.
// - Rightmost hex digit holds lines zero to three.
// - Wrong write length gives syntax error, no change.
// - Checksummed write waits for acknowledge before driving.
// - Write bits aimed at inputs are silently dropped.
// - Event fetch reads and zeroes without losing counts.
// - Label up to sixteen characters, needs unlock.
// - Label write refuses an appended checksum.
// - Power-up loads directions, then applies output preset.
// - Fieldbus enable stores address, active after reset.
// - Power, strap release, or unlocked restart reset mode.
// - Grounded strap forces fallback link settings.
// - Fieldbus disable clears enable, effective after reset.
// - Direction map: one per output, lsb rightmost.
// - Direction queries answer I or O.
// - State queries answer 1 or 0; bad line errors.
// - Hex bit and decimal position select same line.
// - Mode query answers C, D, E, I or T.
// - Period query returns stored signed timer value.
// - Checksummed commands are echoed with checksum when they succeed.
// - Event counter saturates until cleared.
module dioci_top #(
	parameter int NLINES = dioci_pkg::DIOCI_NLINES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] word_len,
	input wire logic [63:0] line_in,
	input wire logic event_in,
	input wire logic fallback_strap_n,
	input wire logic [63:0] nv_dir_init,
	input wire logic [63:0] nv_preset_init,
	input wire dioci_pkg::dioci_smode_t nv_smode_init,
	input wire logic [31:0] nv_period_init,
	input wire logic nv_fb_en_init,
	input wire logic [7:0] nv_fb_addr_init,
	input wire logic [127:0] nv_label_init,
	input wire logic cmd_valid,
	input wire dioci_pkg::dioci_op_t cmd_op,
	input wire logic cmd_chk,
	input wire logic [63:0] cmd_hex,
	input wire logic [4:0] cmd_hex_len,
	input wire logic [7:0] cmd_sel_hi,
	input wire logic [7:0] cmd_sel_lo,
	input wire logic [127:0] cmd_text,
	input wire logic [4:0] cmd_text_len,
	output logic ready,
	output logic [63:0] line_out,
	output logic [63:0] line_oe_n,
	output logic [63:0] dir_map,
	output logic [63:0] preset,
	output dioci_pkg::dioci_smode_t stream_mode,
	output logic [31:0] stream_period,
	output logic [127:0] label,
	output logic fb_en,
	output logic [7:0] fb_addr,
	output logic fb_active,
	output logic fallback_active,
	output logic unlocked,
	output logic out_pending,
	output logic rsp_valid,
	output dioci_pkg::dioci_status_t rsp_status,
	output dioci_pkg::dioci_fmt_t rsp_fmt,
	output logic [63:0] rsp_data,
	output logic [4:0] rsp_len,
	output logic rsp_echo
);
	import dioci_pkg::*;

	function automatic logic [63:0] apply_out(input logic [63:0] cur, input logic [63:0] data,
		input logic [63:0] dir, input logic [63:0] mask);
		logic [63:0] drv;
		drv = dir & mask;
		apply_out = (cur & ~drv) | (data & drv);
	endfunction : apply_out

	dioci_boot_t boot_ff;
	dioci_smode_t smode_ff, mode_sel;
	dioci_status_t rsp_status_ff, nxt_status;
	dioci_fmt_t rsp_fmt_ff, nxt_fmt;
	logic [127:0] label_ff;
	logic [63:0] line_out_ff, dir_ff, preset_ff, pend_data_ff, oe_n_ff, rsp_data_ff, nxt_data, line_mask;
	logic [31:0] period_ff;
	logic [DIOCI_EVT_W-1:0] evt_count;
	logic [7:0] fb_addr_ff;
	logic [6:0] nlines_act;
	logic [5:0] sel_idx;
	logic [4:0] rsp_len_ff, nxt_len, digits;
	logic [3:0] wl;
	logic fb_en_ff, fb_active_ff, fallback_ff, strap_q_ff, unlock_ff, pend_ff, ready_ff, rsp_valid_ff, rsp_echo_ff;
	logic go, is_prot, prot_fail, len_ok, dec_form, sel_ok, evt_clr, label_bad, fb_bad;
	logic out_now, out_hold, ack_go, restart_go, strap_rise, mode_write;

	// Word length is clamped so a bad setup cannot select more lines than exist.
	assign wl = (word_len < DIOCI_WL_MIN) ? DIOCI_WL_MIN : (word_len > DIOCI_WL_MAX) ? DIOCI_WL_MAX : word_len;
	assign nlines_act = (7'({wl, 3'b000}) > 7'(NLINES)) ? 7'(NLINES) : 7'({wl, 3'b000});
	assign digits = 5'({wl, 1'b0});
	assign line_mask = (nlines_act >= 7'h40) ? {64{1'b1}} : ((64'h1 << nlines_act) - 64'h1);

	assign go = cmd_valid && (boot_ff == BOOT_RUN);
	assign is_prot = (cmd_op == OP_LABEL_WRITE) || (cmd_op == OP_PRESET_WRITE) ||
		(cmd_op == OP_FB_ENABLE) || (cmd_op == OP_FB_DISABLE) || (cmd_op == OP_SOFT_RESTART) ||
		(cmd_op == OP_STREAM_CHANGE) || (cmd_op == OP_STREAM_EDGE) ||
		(cmd_op == OP_STREAM_INPUT) || (cmd_op == OP_STREAM_TIMER);
	assign prot_fail = is_prot && !unlock_ff;
	assign len_ok = (cmd_hex_len == digits);
	assign dec_form = (cmd_op == OP_DIR_POS_Q) || (cmd_op == OP_STATE_DEC_Q);
	assign label_bad = cmd_chk || (cmd_text_len > DIOCI_LABEL_MAX);
	assign fb_bad = (cmd_hex_len != DIOCI_FB_ADDR_DIGITS);

	assign evt_clr = go && ((cmd_op == OP_EVT_FETCH_CLR) || (cmd_op == OP_EVT_CLR));
	assign out_now = go && (cmd_op == OP_OUT_WRITE) && len_ok && !cmd_chk;
	assign out_hold = go && (cmd_op == OP_OUT_WRITE) && len_ok && cmd_chk;
	assign ack_go = go && (cmd_op == OP_ACK) && pend_ff;
	assign restart_go = go && (cmd_op == OP_SOFT_RESTART) && unlock_ff;
	assign strap_rise = fallback_strap_n && !strap_q_ff;
	assign mode_write = go && !prot_fail && ((cmd_op == OP_STREAM_CHANGE) || (cmd_op == OP_STREAM_OFF) ||
		(cmd_op == OP_STREAM_EDGE) || (cmd_op == OP_STREAM_INPUT) || (cmd_op == OP_STREAM_TIMER));

	assign mode_sel = (cmd_op == OP_STREAM_CHANGE) ? SM_CHANGE : (cmd_op == OP_STREAM_EDGE) ? SM_EDGE :
		(cmd_op == OP_STREAM_INPUT) ? SM_INPUT : (cmd_op == OP_STREAM_TIMER) ? SM_TIMER : SM_OFF;

	dioci_linesel u_linesel (
		.char_hi(cmd_sel_hi),
		.char_lo(cmd_sel_lo),
		.dec_form(dec_form),
		.nlines(nlines_act),
		.idx(sel_idx),
		.ok(sel_ok)
	);

	dioci_evcnt u_evcnt (
		.core_clk(core_clk),
		.resetn(resetn),
		.evt(event_in),
		.clr(evt_clr),
		.count(evt_count)
	);

	always_comb begin
		nxt_status = ST_OK;
		nxt_fmt = FMT_NONE;
		nxt_data = '0;
		nxt_len = '0;
		if (prot_fail) begin
			nxt_status = ST_PROTECT;
		end else begin
			case (cmd_op)
				OP_LINE_READ: begin
					nxt_fmt = FMT_HEX;
					nxt_data = line_in & line_mask;
					nxt_len = digits;
				end
				OP_OUT_WRITE: begin
					if (!len_ok) begin
						nxt_status = ST_SYNTAX;
					end
				end
				OP_ACK: begin
					if (!pend_ff) begin
						nxt_status = ST_COMMAND;
					end
				end
				OP_EVT_FETCH_CLR: begin
					nxt_fmt = FMT_DEC;
					nxt_data = 64'(evt_count);
					nxt_len = DIOCI_EVT_DIGITS;
				end
				OP_LABEL_WRITE: begin
					if (label_bad) begin
						nxt_status = ST_SYNTAX;
					end
				end
				OP_FB_ENABLE: begin
					if (fb_bad) begin
						nxt_status = ST_SYNTAX;
					end
				end
				OP_DIR_MAP_READ: begin
					nxt_fmt = FMT_HEX;
					nxt_data = dir_ff & line_mask;
					nxt_len = digits;
				end
				OP_DIR_BIT_Q, OP_DIR_POS_Q: begin
					if (!sel_ok) begin
						nxt_status = ST_VALUE;
					end else begin
						nxt_fmt = FMT_CHAR;
						nxt_data = {56'h0, dir_ff[sel_idx] ? DIOCI_CH_O : DIOCI_CH_I};
						nxt_len = DIOCI_CHAR_DIGITS;
					end
				end
				OP_STATE_HEX_Q, OP_STATE_DEC_Q: begin
					if (!sel_ok) begin
						nxt_status = ST_VALUE;
					end else begin
						nxt_fmt = FMT_CHAR;
						nxt_data = {56'h0, line_in[sel_idx] ? DIOCI_CH_1 : DIOCI_CH_0};
						nxt_len = DIOCI_CHAR_DIGITS;
					end
				end
				OP_MODE_Q: begin
					nxt_fmt = FMT_CHAR;
					nxt_data = {56'h0, dioci_mode_char(smode_ff)};
					nxt_len = DIOCI_CHAR_DIGITS;
				end
				OP_PERIOD_Q: begin
					nxt_fmt = FMT_DEC;
					nxt_data = {{32{period_ff[31]}}, period_ff};
					nxt_len = DIOCI_PERIOD_DIGITS;
				end
				OP_NONE: begin
					nxt_status = ST_COMMAND;
				end
				default: begin
					nxt_status = ST_OK;
				end
			endcase
		end
	end

	// Boot sequencing: directions first, preset second, so the preset never drives an input line.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			boot_ff <= BOOT_DIR;
			ready_ff <= 1'b0;
			dir_ff <= DIOCI_RST_LINES;
			preset_ff <= DIOCI_RST_LINES;
			smode_ff <= SM_OFF;
			period_ff <= DIOCI_RST_PERIOD;
			label_ff <= '0;
			fb_en_ff <= 1'b0;
			fb_addr_ff <= DIOCI_RST_FB_ADDR;
		end else begin
			case (boot_ff)
				BOOT_DIR: begin
					dir_ff <= nv_dir_init;
					preset_ff <= nv_preset_init;
					smode_ff <= nv_smode_init;
					period_ff <= nv_period_init;
					label_ff <= nv_label_init;
					fb_en_ff <= nv_fb_en_init;
					fb_addr_ff <= nv_fb_addr_init;
					boot_ff <= BOOT_PRESET;
				end
				BOOT_PRESET: begin
					boot_ff <= BOOT_RUN;
					ready_ff <= 1'b1;
				end
				BOOT_RUN: begin
					if (mode_write) begin
						smode_ff <= mode_sel;
					end
					if (go && !prot_fail && cmd_op == OP_PRESET_WRITE && len_ok) begin
						preset_ff <= cmd_hex;
					end
					if (go && !prot_fail && cmd_op == OP_LABEL_WRITE && !label_bad) begin
						label_ff <= cmd_text;
					end
					if (go && !prot_fail && cmd_op == OP_FB_ENABLE && !fb_bad) begin
						fb_addr_ff <= cmd_hex[7:0];
						fb_en_ff <= 1'b1;
					end
					if (go && !prot_fail && cmd_op == OP_FB_DISABLE) begin
						fb_en_ff <= 1'b0;
					end
				end
				default: begin
					boot_ff <= BOOT_DIR;
				end
			endcase
		end
	end

	// Outputs change only on the preset load, a direct write or an acknowledge; restart leaves them alone.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			line_out_ff <= DIOCI_RST_LINES;
			pend_ff <= 1'b0;
			pend_data_ff <= DIOCI_RST_LINES;
			oe_n_ff <= {64{1'b1}};
		end else begin
			oe_n_ff <= ~(dir_ff & line_mask);
			if (boot_ff == BOOT_PRESET) begin
				line_out_ff <= apply_out(DIOCI_RST_LINES, preset_ff, dir_ff, line_mask);
			end else if (out_now) begin
				line_out_ff <= apply_out(line_out_ff, cmd_hex, dir_ff, line_mask);
			end else if (ack_go) begin
				line_out_ff <= apply_out(line_out_ff, pend_data_ff, dir_ff, line_mask);
			end
			if (out_hold) begin
				pend_ff <= 1'b1;
				pend_data_ff <= cmd_hex;
			end else if (ack_go || out_now) begin
				pend_ff <= 1'b0;
			end
		end
	end

	// The active protocol follows the stored enable only at a reset event, never on the store itself.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fb_active_ff <= 1'b0;
			fallback_ff <= 1'b0;
			strap_q_ff <= 1'b1;
			unlock_ff <= 1'b0;
		end else begin
			strap_q_ff <= fallback_strap_n;
			fallback_ff <= !fallback_strap_n;
			if (boot_ff == BOOT_PRESET || restart_go || strap_rise) begin
				fb_active_ff <= fb_en_ff;
			end
			if (go) begin
				unlock_ff <= (cmd_op == OP_UNLOCK);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rsp_valid_ff <= 1'b0;
			rsp_status_ff <= ST_OK;
			rsp_fmt_ff <= FMT_NONE;
			rsp_data_ff <= '0;
			rsp_len_ff <= '0;
			rsp_echo_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= go;
			if (go) begin
				rsp_status_ff <= nxt_status;
				rsp_fmt_ff <= nxt_fmt;
				rsp_data_ff <= nxt_data;
				rsp_len_ff <= nxt_len;
				rsp_echo_ff <= cmd_chk && (nxt_status == ST_OK);
			end
		end
	end

	assign ready = ready_ff;
	assign line_out = line_out_ff;
	assign line_oe_n = oe_n_ff;
	assign dir_map = dir_ff;
	assign preset = preset_ff;
	assign stream_mode = smode_ff;
	assign stream_period = period_ff;
	assign label = label_ff;
	assign fb_en = fb_en_ff;
	assign fb_addr = fb_addr_ff;
	assign fb_active = fb_active_ff;
	assign fallback_active = fallback_ff;
	assign unlocked = unlock_ff;
	assign out_pending = pend_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_status = rsp_status_ff;
	assign rsp_fmt = rsp_fmt_ff;
	assign rsp_data = rsp_data_ff;
	assign rsp_len = rsp_len_ff;
	assign rsp_echo = rsp_echo_ff;

endmodule : dioci_top

// File: inc/dioci_pkg.sv
package dioci_pkg;

	localparam int DIOCI_NLINES = 64;
	localparam int DIOCI_WORD_BITS = 8;
	localparam int DIOCI_MAX_WORDS = 8;
	localparam int DIOCI_LABEL_CHARS = 16;
	localparam int DIOCI_LABEL_W = 128;
	localparam int DIOCI_EVT_W = 24;
	localparam int DIOCI_PERIOD_W = 32;

	localparam logic [23:0] DIOCI_EVT_MAX = 24'h98967f;
	localparam logic [4:0] DIOCI_EVT_DIGITS = 5'h07;
	localparam logic [4:0] DIOCI_PERIOD_DIGITS = 5'h08;
	localparam logic [4:0] DIOCI_CHAR_DIGITS = 5'h01;
	localparam logic [4:0] DIOCI_FB_ADDR_DIGITS = 5'h02;
	localparam logic [4:0] DIOCI_LABEL_MAX = 5'h10;
	localparam logic [3:0] DIOCI_WL_MIN = 4'h1;
	localparam logic [3:0] DIOCI_WL_MAX = 4'h8;

	localparam logic [63:0] DIOCI_RST_LINES = 64'h0;
	localparam logic [7:0] DIOCI_RST_FB_ADDR = 8'h00;
	localparam logic [31:0] DIOCI_RST_PERIOD = 32'h0;

	localparam logic [7:0] DIOCI_CH_0 = 8'h30;
	localparam logic [7:0] DIOCI_CH_1 = 8'h31;
	localparam logic [7:0] DIOCI_CH_I = 8'h49;
	localparam logic [7:0] DIOCI_CH_O = 8'h4f;
	localparam logic [7:0] DIOCI_CH_C = 8'h43;
	localparam logic [7:0] DIOCI_CH_D = 8'h44;
	localparam logic [7:0] DIOCI_CH_E = 8'h45;
	localparam logic [7:0] DIOCI_CH_T = 8'h54;

	typedef enum logic [4:0] {
		OP_NONE, OP_LINE_READ, OP_OUT_WRITE, OP_ACK, OP_EVT_FETCH_CLR, OP_EVT_CLR,
		OP_LABEL_WRITE, OP_PRESET_WRITE, OP_FB_ENABLE, OP_FB_DISABLE, OP_DIR_MAP_READ,
		OP_DIR_BIT_Q, OP_DIR_POS_Q, OP_STATE_HEX_Q, OP_STATE_DEC_Q, OP_MODE_Q, OP_PERIOD_Q,
		OP_UNLOCK, OP_SOFT_RESTART, OP_STREAM_CHANGE, OP_STREAM_OFF, OP_STREAM_EDGE,
		OP_STREAM_INPUT, OP_STREAM_TIMER
	} dioci_op_t;

	typedef enum logic [2:0] {ST_OK, ST_SYNTAX, ST_VALUE, ST_COMMAND, ST_PROTECT} dioci_status_t;
	typedef enum logic [1:0] {FMT_NONE, FMT_HEX, FMT_CHAR, FMT_DEC} dioci_fmt_t;
	typedef enum logic [2:0] {SM_OFF, SM_CHANGE, SM_EDGE, SM_INPUT, SM_TIMER} dioci_smode_t;
	typedef enum logic [1:0] {BOOT_DIR, BOOT_PRESET, BOOT_RUN} dioci_boot_t;

	function automatic logic [7:0] dioci_mode_char(input dioci_smode_t m);
		case (m)
			SM_CHANGE: dioci_mode_char = DIOCI_CH_C;
			SM_EDGE: dioci_mode_char = DIOCI_CH_E;
			SM_INPUT: dioci_mode_char = DIOCI_CH_I;
			SM_TIMER: dioci_mode_char = DIOCI_CH_T;
			default: dioci_mode_char = DIOCI_CH_D;
		endcase
	endfunction : dioci_mode_char

	function automatic logic [4:0] dioci_char_nibble(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			dioci_char_nibble = {1'b0, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
			dioci_char_nibble = {1'b0, c[3:0] + 4'h9};
		end else begin
			dioci_char_nibble = 5'h10;
		end
	endfunction : dioci_char_nibble

endpackage : dioci_pkg

// File: testbench/dioci_host.sv
`timescale 1ns/1ps
module dioci_host (
	input wire logic core_clk,
	input wire logic ready,
	output logic cmd_valid,
	output dioci_pkg::dioci_op_t cmd_op,
	output logic cmd_chk,
	output logic [63:0] cmd_hex,
	output logic [4:0] cmd_hex_len,
	output logic [7:0] cmd_sel_hi,
	output logic [7:0] cmd_sel_lo,
	output logic [127:0] cmd_text,
	output logic [4:0] cmd_text_len
);
	import dioci_pkg::*;
	initial begin
		cmd_op = OP_NONE;
		{cmd_valid, cmd_chk, cmd_hex, cmd_hex_len, cmd_sel_hi, cmd_sel_lo, cmd_text, cmd_text_len} = '0;
	end
	// Hex, select and text fields flip once taken, so a stale argument can never pass for a fresh one.
	task send(input dioci_op_t op, input logic c, input logic [63:0] h, input logic [4:0] hl,
		input logic [15:0] s, input logic [127:0] t, input logic [4:0] tl);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		cmd_op <= op;
		{cmd_valid, cmd_chk, cmd_hex, cmd_hex_len, cmd_sel_hi, cmd_sel_lo, cmd_text, cmd_text_len} <= {1'b1, c, h, hl, s, t, tl};
		@(posedge core_clk);
		{cmd_valid, cmd_hex, cmd_sel_hi, cmd_sel_lo, cmd_text} <= {1'b0, ~h, ~s, ~t};
		#1;
	endtask : send
	task send_locked(input dioci_op_t op, input logic c, input logic [63:0] h, input logic [4:0] hl,
		input logic [15:0] s, input logic [127:0] t, input logic [4:0] tl);
		send(OP_UNLOCK, 1'b0, 64'h0, 5'h00, 16'h0, 128'h0, 5'h00);
		send(op, c, h, hl, s, t, tl);
	endtask : send_locked
endmodule : dioci_host

// File: testbench/dioci_sva.sv
`timescale 1ns/1ps
module dioci_sva #(
	parameter int NLINES = 64
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] word_len,
	input wire logic fallback_strap_n,
	input wire dioci_pkg::dioci_smode_t nv_smode_init,
	input wire logic cmd_valid,
	input wire dioci_pkg::dioci_op_t cmd_op,
	input wire logic cmd_chk,
	input wire logic [4:0] cmd_hex_len,
	input wire logic ready,
	input wire logic [63:0] line_out,
	input wire logic [63:0] dir_map,
	input wire logic [63:0] preset,
	input wire dioci_pkg::dioci_smode_t stream_mode,
	input wire logic fb_active,
	input wire logic fallback_active,
	input wire logic unlocked,
	input wire logic out_pending,
	input wire logic rsp_valid,
	input wire dioci_pkg::dioci_status_t rsp_status,
	input wire logic rsp_echo
);
	import dioci_pkg::*;
	logic from_boot_ff;
	wire logic take = cmd_valid && ready;
	wire logic [63:0] wl_mask = ~(64'hffff_ffff_ffff_ffff << {word_len, 3'h0});
	// A soft restart leaves ready alone and must not reload outputs, so only the boot rise of ready counts here.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			from_boot_ff <= 1'b1;
		end else if (ready) begin
			from_boot_ff <= 1'b0;
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	a_echo_checksum: assert property (take && cmd_chk && cmd_op == OP_DIR_MAP_READ |=> rsp_valid && rsp_echo)
		else $error("checksum echo missing");
	a_length_syntax: assert property (take && cmd_op == OP_OUT_WRITE && cmd_hex_len != {word_len, 1'b0}
		|=> rsp_status == ST_SYNTAX && $stable(line_out))
		else $error("bad length accepted");
	a_hold_until_ack: assert property (out_pending && !cmd_valid |=> $stable(line_out))
		else $error("outputs moved before ack");
	a_ack_drives: assert property (take && cmd_op == OP_ACK && out_pending |=> !out_pending && rsp_status == ST_OK)
		else $error("ack not applied");
	a_inputs_untouched: assert property (ready |-> (line_out & ~dir_map) == 64'h0)
		else $error("input line driven");
	a_boot_preset: assert property ($rose(ready) && from_boot_ff |-> line_out == (preset & dir_map & wl_mask))
		else $error("preset not applied");
	a_boot_mode: assert property ($rose(ready) && from_boot_ff |-> stream_mode == nv_smode_init)
		else $error("stored mode not applied");
	a_strap_fallback: assert property (!fallback_strap_n |=> fallback_active)
		else $error("fallback not entered");
	a_fb_deferred: assert property (take && (cmd_op == OP_FB_ENABLE || cmd_op == OP_FB_DISABLE) |=> $stable(fb_active))
		else $error("protocol switched early");
	a_protect_stream: assert property (take && !unlocked && cmd_op == OP_STREAM_CHANGE
		|=> rsp_status == ST_PROTECT && $stable(stream_mode))
		else $error("locked mode change accepted");
	a_off_unprotected: assert property (take && cmd_op == OP_STREAM_OFF |=> stream_mode == SM_OFF)
		else $error("stream off refused");
endmodule : dioci_sva
bind dioci_top dioci_sva #(.NLINES(NLINES)) u_sva (.*);

// File: testbench/test_digital_io_command_interpreter.sv
`timescale 1ns/1ps
module test_digital_io_command_interpreter;
	import dioci_pkg::*;
	logic core_clk, resetn, event_in, fallback_strap_n, nv_fb_en_init, cmd_valid, cmd_chk, ready, fb_en;
	logic fb_active, fallback_active, unlocked, out_pending, rsp_valid, rsp_echo;
	logic [3:0] word_len;
	logic [4:0] cmd_hex_len, cmd_text_len, rsp_len;
	logic [7:0] nv_fb_addr_init, fb_addr, cmd_sel_hi, cmd_sel_lo;
	logic [31:0] nv_period_init, stream_period;
	logic [31:0] mch = "CEIT";
	logic [63:0] line_in, nv_dir_init, nv_preset_init, cmd_hex, line_out, line_oe_n, dir_map, preset, rsp_data;
	logic [127:0] nv_label_init, cmd_text, label, lbl;
	logic [15:0] hx [3] = '{"0A", "0F", "10"};
	logic [15:0] dc [3] = '{"10", "15", "16"};
	logic [7:0] dq [2] = '{"O", "I"};
	logic [7:0] sq [2] = '{"0", "1"};
	dioci_smode_t nv_smode_init, stream_mode;
	dioci_op_t cmd_op;
	dioci_op_t qop [4] = '{OP_DIR_BIT_Q, OP_DIR_POS_Q, OP_STATE_HEX_Q, OP_STATE_DEC_Q};
	dioci_op_t sop [4] = '{OP_STREAM_CHANGE, OP_STREAM_EDGE, OP_STREAM_INPUT, OP_STREAM_TIMER};
	dioci_status_t rsp_status;
	dioci_fmt_t rsp_fmt;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	dioci_top u_dut (.*);
	dioci_host u_host (.*);
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	task print_verdict;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task run(input dioci_op_t op, input dioci_status_t st = ST_OK, input logic u = 1'b0, input logic c = 1'b0,
		input logic [63:0] h = 64'h0, input logic [4:0] hl = 5'h00, input logic [15:0] s = 16'h0);
		if (u) begin
			u_host.send_locked(op, c, h, hl, s, lbl, 5'h10);
		end else begin
			u_host.send(op, c, h, hl, s, lbl, 5'h10);
		end
		chk("rsp_valid", 64'h1, rsp_valid);
		chk("rsp_status", st, rsp_status);
	endtask : run
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		word_len = 4'h2;
		line_in = 64'h5a5a_c3c3_0000_8034;
		event_in = 1'b0;
		fallback_strap_n = 1'b1;
		nv_dir_init = 64'h00ff_00ff_0000_0f0f;
		nv_preset_init = 64'hffff_ffff_ffff_00ff;
		nv_smode_init = SM_TIMER;
		nv_period_init = 32'hffff_fe0c;
		nv_fb_en_init = 1'b0;
		nv_fb_addr_init = 8'h00;
		nv_label_init = 128'h0;
		lbl = "TANK LEVEL 4 NOW";
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk("line_out", 64'h000f, line_out);
		chk("line_oe_n", ~64'h0f0f, line_oe_n);
		chk("stream_mode", SM_TIMER, stream_mode);
		run(OP_LINE_READ);
		chk("line_read", 64'h8034, rsp_data);
		chk("read_len", 64'h4, rsp_len);
		run(OP_DIR_MAP_READ, ST_OK, 1'b0, 1'b1);
		chk("dir_map", 64'h0f0f, rsp_data);
		chk("echo", 64'h1, rsp_echo);
		run(OP_PERIOD_Q);
		chk("period", {32'hffff_ffff, nv_period_init}, rsp_data);
		chk("period_fmt", FMT_DEC, rsp_fmt);
		chk("stream_period", nv_period_init, stream_period);
		run(OP_OUT_WRITE, ST_SYNTAX, 1'b0, 1'b0, 64'h12345, 5'h05);
		chk("line_out", 64'h000f, line_out);
		run(OP_OUT_WRITE, ST_OK, 1'b0, 1'b1, 64'hffff, 5'h04);
		chk("pending", 64'h1, out_pending);
		chk("line_out", 64'h000f, line_out);
		run(OP_ACK);
		chk("line_out", 64'h0f0f, line_out);
		run(OP_ACK, ST_COMMAND);
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 4; j++) begin
				run(qop[j], i == 2 ? ST_VALUE : ST_OK, 1'b0, 1'b0, 64'h0, 5'h00, j[0] ? dc[i] : hx[i]);
				if (i < 2) chk("line_char", {56'h0, (j < 2) ? dq[i] : sq[i]}, rsp_data);
			end
		end
		@(posedge core_clk);
		event_in <= 1'b1;
		repeat (5) @(posedge core_clk);
		event_in <= 1'b0;
		run(OP_EVT_FETCH_CLR);
		chk("events", 64'h5, rsp_data);
		chk("event_len", 64'h7, rsp_len);
		@(posedge core_clk);
		event_in <= 1'b1;
		run(OP_EVT_CLR);
		@(posedge core_clk);
		event_in <= 1'b0;
		run(OP_EVT_FETCH_CLR);
		chk("events", 64'h2, rsp_data);
		run(OP_EVT_FETCH_CLR);
		chk("events", 64'h0, rsp_data);
		run(OP_STREAM_CHANGE, ST_PROTECT);
		chk("stream_mode", SM_TIMER, stream_mode);
		run(OP_STREAM_OFF);
		run(OP_MODE_Q);
		chk("mode_char", {56'h0, "D"}, rsp_data);
		for (int k = 0; k < 4; k++) begin
			run(sop[k], ST_OK, 1'b1);
			run(OP_MODE_Q);
			chk("mode_char", {56'h0, mch[31 - 8 * k -: 8]}, rsp_data);
		end
		run(OP_LABEL_WRITE, ST_PROTECT);
		run(OP_LABEL_WRITE, ST_SYNTAX, 1'b1, 1'b1);
		run(OP_LABEL_WRITE, ST_OK, 1'b1);
		chk("label_hi", lbl[127:64], label[127:64]);
		chk("label_lo", lbl[63:0], label[63:0]);
		run(OP_PRESET_WRITE, ST_OK, 1'b1, 1'b0, 64'h00aa, 5'h04);
		chk("preset", 64'h00aa, preset);
		run(OP_FB_ENABLE, ST_OK, 1'b1, 1'b0, 64'h5a, 5'h02);
		chk("fb_addr", 64'h5a, fb_addr);
		chk("fb_active", 64'h0, fb_active);
		run(OP_SOFT_RESTART, ST_OK, 1'b1);
		repeat (4) @(posedge core_clk);
		run(OP_FB_DISABLE, ST_OK, 1'b1);
		chk("fb_active", 64'h1, fb_active);
		chk("fb_en", 64'h0, fb_en);
		chk("line_out", 64'h0f0f, line_out);
		@(posedge core_clk);
		fallback_strap_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("fallback", 64'h1, fallback_active);
		@(posedge core_clk);
		fallback_strap_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk("fb_active", 64'h0, fb_active);
		@(posedge core_clk);
		word_len <= 4'h8;
		run(OP_LINE_READ);
		chk("line_read", line_in, rsp_data);
		chk("read_len", 64'h10, rsp_len);
		run(OP_OUT_WRITE, ST_OK, 1'b0, 1'b0, 64'hffff_ffff_ffff_ffff, 5'h10);
		chk("line_out", 64'h00ff_00ff_0000_0f0f, line_out);
		print_verdict();
	end
endmodule : test_digital_io_command_interpreter
